// file: verilog/ndc_default_select.v
// Default configuration selector: RAM versus stored defaults, write gating, upload
`include "ndc_select_map.vh"

module ndc_default_select #(
	parameter NF = `NDC_NFIELDS,
	parameter FW = `NDC_FW
) (
	// Clock and reset
	input  wire              i_ref_clk,
	input  wire              i_resetn,
	// Device state from the state machine, same clock
	input  wire [2:0]        i_dev_state,
	// Stored default set as read from the customer sector
	input  wire [NF*FW-1:0]  i_nvm_default,
	// Field write port from the serial interface decoder
	input  wire              i_wr_valid,
	input  wire [5:0]        i_wr_field,
	input  wire [FW-1:0]     i_wr_data,
	// Configuration views
	output reg  [NF*FW-1:0]  o_ram_cfg,
	output reg  [NF*FW-1:0]  o_eff_cfg,
	// Status
	output reg               o_wr_refused,
	output reg               o_default_active,
	output reg               o_default_upload_trigger,
	// Control levels
	output reg               o_output_switch_control,
	output reg               o_bypass_switch_control,
	output reg               o_selftest_cfg,
	output reg               o_locked_mode_en,
	// Control pulses
	output reg               o_selftest_start,
	output reg               o_selftest_stop,
	output reg               o_unlocked_request,
	output reg               o_standby_request,
	output reg               o_cap_charge_go,
	output reg               o_cap_charge_halt,
	output reg               o_unlock,
	output reg               o_watchdog_kick
);

	// Use class of each mapped field
	function [1:0] ndc_use;
		input integer idx;
		begin
			if (idx == `NDC_F_DIN_EN || idx == `NDC_F_DIN_OPT) begin
				ndc_use = `NDC_USE_LOCKED;
			end else if (idx == `NDC_F_BYPASS) begin
				ndc_use = `NDC_USE_FS_SB;
			end else if (idx == `NDC_F_FAILSAFE_OUTPUT_MODE) begin
				ndc_use = `NDC_USE_FS;
			end else begin
				ndc_use = `NDC_USE_BOTH;
			end
		end
	endfunction

	// Control fields still writable in fail-safe output mode 10/11
	function ndc_fs_ctl_ok;
		input [5:0] fld;
		begin
			ndc_fs_ctl_ok = (fld == `NDC_C_UNLK_REQ) || (fld == `NDC_C_STANDBY) ||
				(fld == `NDC_C_UPLOAD) || (fld == `NDC_C_UNLOCK);
		end
	endfunction

	// State decode
	wire in_fs = (i_dev_state == `NDC_ST_FAILSAFE);
	wire in_lk = (i_dev_state == `NDC_ST_LOCKED);
	wire in_sb = (i_dev_state == `NDC_ST_STANDBY);
	wire in_st = (i_dev_state == `NDC_ST_SELFTEST);
	wire in_ul = (i_dev_state == `NDC_ST_UNLOCKED);

	// Enable bit taken from the stored set, never from the RAM copy
	wire def_en = i_nvm_default[`NDC_F_DEF_EN*FW];
	// Stored and RAM fail-safe output modes
	wire [1:0] nvm_failsafe_output_mode = i_nvm_default[`NDC_F_FAILSAFE_OUTPUT_MODE*FW +: 2];
	wire [1:0] ram_failsafe_output_mode = o_ram_cfg[`NDC_F_FAILSAFE_OUTPUT_MODE*FW +: 2];

	wire def_fs_ok = def_en && (nvm_failsafe_output_mode != `NDC_FS_OFF);
	// Defaults live in fail-safe
	wire def_in_fs = in_fs && def_fs_ok;
	// Output mode actually in force during fail-safe
	wire [1:0] act_failsafe_output_mode = def_in_fs ? nvm_failsafe_output_mode : ram_failsafe_output_mode;

	wire fs_wr_lock = in_fs && act_failsafe_output_mode[1];

	// Field class of the incoming write
	wire is_map = (i_wr_field < NF);
	wire is_ctl = !is_map && (i_wr_field <= `NDC_C_WD_KICK);

	// Mapped writes refused in fail-safe mode 10/11 and in locked with defaults off
	wire map_ok = !fs_wr_lock && !(in_lk && !def_en);
	// Control fields stay open in locked; fail-safe mode 10/11 keeps a few
	wire ctl_ok = !fs_wr_lock || ndc_fs_ctl_ok(i_wr_field);

	// Accepted writes
	wire wr_map = i_wr_valid && is_map && map_ok;
	wire wr_ctl = i_wr_valid && is_ctl && ctl_ok;
	wire set1   = i_wr_data[0];

	// Upload has no effect in fail-safe with defaults off
	wire upload_go = wr_ctl && (i_wr_field == `NDC_C_UPLOAD) && set1 && !(in_fs && !def_en);

	// Per-field selection and storage
	genvar gi;
	generate
		for (gi = 0; gi < NF; gi = gi + 1) begin : g_fld
			wire [1:0] use_cls = ndc_use(gi);
			reg        apply;

			// Decide whether the stored default governs this field now
			always @* begin
				case (use_cls)
					`NDC_USE_LOCKED: apply = def_en && in_lk;
					`NDC_USE_FS_SB:  apply = def_in_fs || (def_en && in_sb);
					`NDC_USE_FS:     apply = def_in_fs;
					`NDC_USE_BOTH:   apply = def_in_fs || (def_en && in_lk);
					default:         apply = 1'b0;
				endcase
			end

			// Effective view, registered so consumers see clean values
			always @(posedge i_ref_clk) begin
				if (!i_resetn) begin
					o_eff_cfg[gi*FW +: FW] <= {FW{1'b0}};
				end else if (gi == `NDC_F_DEF_EN) begin
					// Only the stored enable is ever effective
					o_eff_cfg[gi*FW +: FW] <= i_nvm_default[gi*FW +: FW];
				end else begin
					o_eff_cfg[gi*FW +: FW] <= apply ? i_nvm_default[gi*FW +: FW]
						: o_ram_cfg[gi*FW +: FW];
				end
			end

			// RAM copy: upload beats a user write in the same cycle
			always @(posedge i_ref_clk) begin
				if (!i_resetn) begin
					o_ram_cfg[gi*FW +: FW] <= {FW{1'b0}};
				end else if (o_default_upload_trigger) begin
					o_ram_cfg[gi*FW +: FW] <= i_nvm_default[gi*FW +: FW];
				end else if (wr_map && (i_wr_field == gi)) begin
					o_ram_cfg[gi*FW +: FW] <= i_wr_data;
				end
			end
		end
	endgenerate

	// Upload trigger: held one cycle while the copy happens
	always @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			o_default_upload_trigger <= 1'b0;
		end else begin
			o_default_upload_trigger <= upload_go;
		end
	end

	// Summary flag of defaults in force
	always @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			o_default_active <= 1'b0;
		end else begin
			// Nothing applies without the stored enable
			o_default_active <= def_in_fs || (def_en && (in_lk || in_sb));
		end
	end

	// Refusal pulse for any write not taken
	always @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			o_wr_refused <= 1'b0;
		end else begin
			o_wr_refused <= i_wr_valid && !wr_map && !wr_ctl;
		end
	end

	// Control levels, kept until rewritten
	always @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			o_output_switch_control <= 1'b0;
			o_bypass_switch_control <= 1'b0;
			o_selftest_cfg          <= 1'b0;
			o_locked_mode_en        <= 1'b0;
		end else if (wr_ctl) begin
			case (i_wr_field)
				`NDC_C_OUTPUT_SWITCH_CONTROL:  o_output_switch_control <= set1;
				`NDC_C_BYPASS:  o_bypass_switch_control <= set1;
				`NDC_C_ST_CFG:  o_selftest_cfg          <= set1;
				`NDC_C_LOCK_EN: o_locked_mode_en        <= set1;
				default: begin
					// Trigger fields handled below; upload handled above
					o_locked_mode_en <= o_locked_mode_en;
				end
			endcase
		end
	end

	// Trigger pulses, one cycle after an accepted write of one
	always @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			o_selftest_start   <= 1'b0;
			o_selftest_stop    <= 1'b0;
			o_unlocked_request <= 1'b0;
			o_standby_request  <= 1'b0;
			o_cap_charge_go    <= 1'b0;
			o_cap_charge_halt  <= 1'b0;
			o_unlock           <= 1'b0;
			o_watchdog_kick    <= 1'b0;
		end else begin
			o_selftest_start   <= wr_ctl && set1 && (i_wr_field == `NDC_C_ST_START);
			// Stop ignored outside unlocked and self-test
			o_selftest_stop    <= wr_ctl && set1 && (i_wr_field == `NDC_C_ST_STOP) &&
				(in_ul || in_st);
			o_unlocked_request <= wr_ctl && set1 && (i_wr_field == `NDC_C_UNLK_REQ);
			o_standby_request  <= wr_ctl && set1 && (i_wr_field == `NDC_C_STANDBY);
			o_cap_charge_go    <= wr_ctl && set1 && (i_wr_field == `NDC_C_CHG_GO);
			o_cap_charge_halt  <= wr_ctl && set1 && (i_wr_field == `NDC_C_CHG_HALT);
			o_unlock           <= wr_ctl && set1 && (i_wr_field == `NDC_C_UNLOCK);
			o_watchdog_kick    <= wr_ctl && set1 && (i_wr_field == `NDC_C_WD_KICK);
		end
	end

endmodule

// file: verilog/ndc_select_map.vh
// Constants for the default configuration selector: states, field indices, codes
`ifndef NDC_SELECT_MAP_VH
`define NDC_SELECT_MAP_VH

// Device state codes on i_dev_state
`define NDC_ST_UNLOCKED  3'h0
`define NDC_ST_LOCKED    3'h1
`define NDC_ST_FAILSAFE  3'h2
`define NDC_ST_STANDBY   3'h3
`define NDC_ST_SELFTEST  3'h4

// Mapped field count and slot width
`define NDC_NFIELDS      20
`define NDC_FW           8

// Mapped configuration fields, indices 0..19
`define NDC_F_DIN_EN     6'h00
`define NDC_F_DIN_OPT    6'h01
`define NDC_F_BYPASS     6'h02
`define NDC_F_FAILSAFE_OUTPUT_MODE    6'h03
`define NDC_F_DEF_EN     6'h04
`define NDC_F_TNOM       6'h05
`define NDC_F_OVC_THR    6'h06
`define NDC_F_HSC_THR    6'h07
`define NDC_F_VDS_THR    6'h08
`define NDC_F_NTC_THR    6'h09
`define NDC_F_WD_TIME    6'h0A
`define NDC_F_UV_THR     6'h0B
`define NDC_F_RETRY_T    6'h0C
`define NDC_F_CCM_VOUT   6'h0D
`define NDC_F_CCM_TON_MF 6'h0E
`define NDC_F_CCM_TON    6'h0F
`define NDC_F_CCM_T      6'h10
`define NDC_F_CCM_SC_T   6'h11
`define NDC_F_CCM_SC_NB  6'h12
`define NDC_F_CCM_TMO    6'h13

// Unmapped control fields
`define NDC_C_OUTPUT_SWITCH_CONTROL     6'h14
`define NDC_C_BYPASS     6'h15
`define NDC_C_ST_START   6'h16
`define NDC_C_ST_STOP    6'h17
`define NDC_C_ST_CFG     6'h18
`define NDC_C_UNLK_REQ   6'h19
`define NDC_C_STANDBY    6'h1A
`define NDC_C_CHG_GO     6'h1B
`define NDC_C_CHG_HALT   6'h1C
`define NDC_C_LOCK_EN    6'h1D
`define NDC_C_UPLOAD     6'h1E
`define NDC_C_UNLOCK     6'h1F
`define NDC_C_WD_KICK    6'h20

// Fail-safe output mode codes (00 and 01 both mean direct input)
`define NDC_FS_LAST      2'h2
`define NDC_FS_OFF       2'h3

// Use classes of the stored defaults
`define NDC_USE_LOCKED   2'h0
`define NDC_USE_FS_SB    2'h1
`define NDC_USE_FS       2'h2
`define NDC_USE_BOTH     2'h3

`endif

// file: bench/ndc_host_model.sv
// Host-side model: issues single field writes as the serial decoder would
module ndc_host (
	// Clock
	input  wire       i_ref_clk,
	// Field write port towards the selector
	output reg        o_wr_valid,
	output reg  [5:0] o_wr_field,
	output reg  [7:0] o_wr_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle port at time zero
	initial begin
		o_wr_valid = 1'b0;
		o_wr_field = 6'h3F;
		o_wr_data  = 8'h00;
	end
	// One write, strobe held for exactly one rising edge
	task put(input [5:0] f, input [7:0] d);
		@(negedge i_ref_clk);
		o_wr_valid = 1'b1;
		o_wr_field = f;
		o_wr_data  = d;
		@(negedge i_ref_clk);
		// Scramble released qualifiers so stale values never look valid
		o_wr_valid = 1'b0;
		o_wr_field = ~f;
		o_wr_data  = ~d;
	endtask
endmodule

// file: bench/ndc_sel_checker.sv
// Port checker for the default configuration selector
`include "ndc_select_map.vh"
module ndc_sel_checker #(
	parameter NF = 20,
	parameter FW = 8
) (
	input wire             i_ref_clk,
	input wire             i_resetn,
	input wire [2:0]       i_dev_state,
	input wire [NF*FW-1:0] i_nvm_default,
	input wire             i_wr_valid,
	input wire [5:0]       i_wr_field,
	input wire [FW-1:0]    i_wr_data,
	input wire [NF*FW-1:0] o_ram_cfg,
	input wire [NF*FW-1:0] o_eff_cfg,
	input wire             o_wr_refused,
	input wire             o_default_upload_trigger,
	input wire             o_selftest_stop
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);
	// Stored enable and fail-safe state with a usable stored mode
	wire en = i_nvm_default[32];
	wire fs = i_dev_state == `NDC_ST_FAILSAFE;
	wire fs_ok = fs && en && (i_nvm_default[25:24] != 2'h3);
	// Upload request, then one trigger cycle and the copied image
	sequence up_req;
		i_wr_valid && i_wr_field == `NDC_C_UPLOAD && i_wr_data[0] && i_dev_state == 3'h0;
	endsequence
	sequence up_done;
		o_default_upload_trigger ##1 (!o_default_upload_trigger && o_ram_cfg == $past(i_nvm_default));
	endsequence
	upload_copy_a:
	assert property (up_req |=> up_done) else $error("upload copy wrong");
	fs_write_a:
	assert property (i_wr_valid && i_wr_field < 6'h14 && fs && en && !i_nvm_default[25]
		&& !o_default_upload_trigger |=> o_ram_cfg[$past(i_wr_field)*FW +: FW] == $past(i_wr_data))
		else $error("fail-safe write lost");
	eff_ram_a:
	assert property (i_dev_state == 3'h0 || (fs && en && i_nvm_default[25:24] == 2'h3)
		|=> o_eff_cfg[47:40] == $past(o_ram_cfg[47:40])) else $error("eff not ram");
	eff_locked_a:
	assert property (i_dev_state == `NDC_ST_LOCKED && en
		|=> o_eff_cfg[47:40] == $past(i_nvm_default[47:40])) else $error("eff not default");
	lock_block_a:
	assert property (i_wr_valid && i_wr_field < 6'h14 && i_dev_state == `NDC_ST_LOCKED && !en
		&& !o_default_upload_trigger |=> o_wr_refused && $stable(o_ram_cfg))
		else $error("locked write taken");
	stop_ignore_a:
	assert property (i_wr_valid && i_wr_field == `NDC_C_ST_STOP && i_dev_state != 3'h0
		&& i_dev_state != `NDC_ST_SELFTEST |=> !o_selftest_stop) else $error("stop pulsed");
	fs_refuse_a:
	assert property (i_wr_valid && i_wr_field == `NDC_C_OUTPUT_SWITCH_CONTROL && fs && en
		&& i_nvm_default[25:24] == 2'h2 |=> o_wr_refused) else $error("fs write taken");
	bypass_sb_a:
	assert property (i_dev_state == `NDC_ST_STANDBY && en
		|=> o_eff_cfg[23:16] == $past(i_nvm_default[23:16])) else $error("bypass default");
	din_fs_a:
	assert property (fs_ok |=> o_eff_cfg[7:0] == $past(o_ram_cfg[7:0])) else $error("din default");
endmodule
bind ndc_default_select ndc_sel_checker #(.NF(NF), .FW(FW)) u_chk (.i_ref_clk, .i_resetn,
	.i_dev_state, .i_nvm_default, .i_wr_valid, .i_wr_field, .i_wr_data, .o_ram_cfg,
	.o_eff_cfg, .o_wr_refused, .o_default_upload_trigger, .o_selftest_stop);

// file: bench/nvm_default_config_select_tb_top.sv
// Testbench for the default configuration selector
`include "ndc_select_map.vh"
module nvm_default_config_select_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	reg          i_ref_clk = 1'b0;
	reg          i_resetn = 1'b0;
	reg  [2:0]   st = 3'h0;
	reg  [159:0] nvm;
	wire         v, rf, up, osc, stp, sby, act;
	wire [5:0]   f;
	wire [7:0]   d;
	wire [159:0] ram, eff;
	integer      n_mismatch = 0;
	integer      samples_checked = 0;
	integer      i, k;
	always #4 i_ref_clk = ~i_ref_clk;
	ndc_host host (.i_ref_clk(i_ref_clk), .o_wr_valid(v), .o_wr_field(f), .o_wr_data(d));
	ndc_default_select DUT (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_dev_state(st),
		.i_nvm_default(nvm), .i_wr_valid(v), .i_wr_field(f), .i_wr_data(d), .o_ram_cfg(ram),
		.o_eff_cfg(eff), .o_wr_refused(rf), .o_default_active(act), .o_default_upload_trigger(up),
		.o_output_switch_control(osc), .o_bypass_switch_control(), .o_selftest_cfg(),
		.o_locked_mode_en(), .o_selftest_start(), .o_selftest_stop(stp),
		.o_unlocked_request(), .o_standby_request(sby), .o_cap_charge_go(),
		.o_cap_charge_halt(), .o_unlock(), .o_watchdog_kick());
	// Byte compare
	task chk(input [7:0] got, input [7:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Flag compare
	task chk_bit(input got, input exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask
	function [7:0] fe(input [159:0] x, input integer n);
		fe = x[n*8 +: 8];
	endfunction
	// Stored image: field n holds 10h+n, plus enable and fail-safe mode
	task mk(input e, input [1:0] m);
		for (k = 0; k < 20; k = k + 1)
			nvm[k*8 +: 8] = 8'h10 + k[7:0];
		nvm[39:24] = {7'h00, e, 6'h00, m};
	endtask
	// State change, then let the one-cycle selection lag pass
	task go(input [2:0] s);
		@(negedge i_ref_clk);
		st = s;
		repeat (2) @(negedge i_ref_clk);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Hang guard
	initial begin
		#100000;
		n_mismatch = n_mismatch + 1;
		print_verdict;
	end
	initial begin
		mk(1'b1, 2'h0);
		repeat (3) @(negedge i_ref_clk);
		i_resetn = 1'b1;
		chk(fe(ram, 5), 8'h00);
		host.put(6'h05, 8'hA5);
		host.put(6'h03, 8'h01);
		host.put(6'h02, 8'h22);
		host.put(6'h04, 8'h00);
		@(negedge i_ref_clk);
		chk(fe(eff, 5), 8'hA5);
		go(`NDC_ST_LOCKED);
		chk(fe(eff, 5), 8'h15);
		chk_bit(act, 1'b1);
		chk(fe(eff, 4), 8'h01);
		chk(fe(eff, 0), 8'h10);
		chk(fe(eff, 2), 8'h22);
		chk(fe(eff, 3), 8'h01);
		host.put(6'h06, 8'h66);
		chk(fe(ram, 6), 8'h66);
		chk(fe(eff, 6), 8'h16);
		go(3'h0);
		chk(fe(eff, 6), 8'h66);
		$display("test locked_enabled done");
		mk(1'b0, 2'h0);
		go(`NDC_ST_LOCKED);
		chk(fe(eff, 5), 8'hA5);
		host.put(6'h07, 8'h77);
		chk_bit(rf, 1'b1);
		chk(fe(ram, 7), 8'h00);
		host.put(`NDC_C_OUTPUT_SWITCH_CONTROL, 8'h01);
		chk_bit(osc, 1'b1);
		host.put(`NDC_C_ST_STOP, 8'h01);
		chk_bit(stp, 1'b0);
		go(`NDC_ST_FAILSAFE);
		host.put(`NDC_C_UPLOAD, 8'h01);
		chk_bit(up, 1'b0);
		go(3'h0);
		host.put(`NDC_C_ST_STOP, 8'h01);
		chk_bit(stp, 1'b1);
		$display("test locked_disabled done");
		mk(1'b1, 2'h0);
		go(`NDC_ST_FAILSAFE);
		chk(fe(eff, 3), 8'h00);
		chk(fe(eff, 0), 8'h00);
		chk(fe(eff, 2), 8'h12);
		host.put(6'h08, 8'h88);
		chk(fe(ram, 8), 8'h88);
		chk(fe(eff, 8), 8'h18);
		go(3'h0);
		mk(1'b1, 2'h3);
		go(`NDC_ST_FAILSAFE);
		chk(fe(eff, 5), 8'hA5);
		chk_bit(act, 1'b0);
		go(3'h0);
		mk(1'b1, 2'h2);
		go(`NDC_ST_FAILSAFE);
		chk(fe(eff, 5), 8'h15);
		host.put(`NDC_C_OUTPUT_SWITCH_CONTROL, 8'h00);
		chk_bit(rf, 1'b1);
		host.put(`NDC_C_STANDBY, 8'h01);
		chk_bit(sby, 1'b1);
		go(`NDC_ST_STANDBY);
		chk(fe(eff, 2), 8'h12);
		chk(fe(eff, 5), 8'hA5);
		$display("test failsafe done");
		go(3'h0);
		for (i = 0; i < 2; i = i + 1) begin
			host.put(6'h09, 8'h99);
			host.put(`NDC_C_UPLOAD, 8'h01);
			chk_bit(up, 1'b1);
			@(negedge i_ref_clk);
			chk_bit(up, 1'b0);
			for (k = 0; k < 20; k = k + 1)
				chk(fe(ram, k), fe(nvm, k));
		end
		$display("test upload done");
		print_verdict;
	end
endmodule
